// ==== design/lamp_pkg.sv ====
package lamp_pkg;

   // Timing figures
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned SELFTEST_MIN_MS = 2000;
   localparam int unsigned SELFTEST_MAX_MS = 5000;
   localparam int unsigned FLASH_HALF_MS   = 250;
   localparam int unsigned FLASH_COUNT     = 3;
   localparam int unsigned SELFTEST_MIN_CYC = (SELFTEST_MIN_MS * (CLK_HZ / 1000));
   localparam int unsigned FLASH_HALF_CYC   = (FLASH_HALF_MS * (CLK_HZ / 1000));

   // Card-state lamp sequencing
   typedef enum logic [2:0]
   {
      ST_TESTING  = 3'h0,
      ST_FLASH_ON = 3'h1,
      ST_FLASH_OFF= 3'h2,
      ST_PASSED   = 3'h3,
      ST_FAILED   = 3'h4,
      ST_ACTIVE   = 3'h5
   } card_state_t;

   // Receive-side alarm inputs
   typedef struct packed
   {
      logic loss_of_signal;
      logic bit_error_over;
      logic slip_over;
   } rx_alarm_t;

   // Operator terminal settings
   typedef struct packed
   {
      logic auto_release;
      logic alarm_ack;
      logic tests_running;
      logic alarms_disabled;
   } operator_menu_t;

endpackage

// ==== design/t1_card_alarm_led_control.sv ====
`timescale 1ns/10ps
`default_nettype none
module t1_card_alarm_led_control
   import lamp_pkg::*;
#(
   parameter int unsigned SELFTEST_MIN = SELFTEST_MIN_CYC,
   parameter int unsigned FLASH_HALF   = FLASH_HALF_CYC
)
(
   input  wire logic           ref_clk,
   input  wire logic           rst_n,
   input  wire logic           selftest_done,
   input  wire logic           selftest_pass,
   input  wire logic           slot_a_enabled,
   input  wire logic           slot_b_enabled,
   input  wire rx_alarm_t      rx_alarm,
   input  wire logic           yellow_rx,
   input  wire operator_menu_t operator_terminal_menu,
   output logic                card_state_lamp,
   output logic                near_end_alarm_lamp,
   output logic                far_end_alarm_lamp,
   output logic                test_activity_lamp,
   output logic                yellow_tx
);

   logic        rst_meta_reg;
   logic        rst_sync_reg;
   card_state_t state_reg;
   card_state_t state_next;
   logic [31:0] timer_reg;
   logic [1:0]  flashes_reg;
   logic        near_alarm;
   logic        latch_reg;
   logic        any_slot;
   logic        alarm_clear;
   logic        test_activity_lamp_request;

   ////////////////////////////////////////////////////////////////////////
   // Behaviour notes
   //
   // Reset
   // - Pin reset asserts at once
   // - Release passes through two flops
   // - Logic leaves reset on the second edge after release
   // - Card-state lamp lit during reset
   // - All other lamps dark during reset
   // - Yellow toward the far end idle during reset
   //
   // Card-state lamp sequencing
   // - Lit steadily while the self-test runs
   // - Test result ignored before the minimum hold time
   // - Upper bound of the test time left to the test source
   // - Pass: dark half period, lit half period, three times
   // - After the third flash: steady lit until a slot enables
   // - Fail: lit until the next reset
   // - Slots ignored after a failed test
   // - Slot changes ignored until the flash sequence ends
   // - Either slot enabled: dark on the next cycle
   // - Second slot enabling: no visible change
   // - One slot disabling: still dark
   // - Both slots disabled: lit again on the next cycle
   //
   // Sequencer states
   // - Testing: waiting for the result and the hold time
   // - Flash dark: gap of one flash
   // - Flash lit: lit half of one flash
   // - Passed: tested, not yet enabled, lamp lit
   // - Active: enabled by software, lamp dark
   // - Failed: terminal until reset
   //
   // Near-end alarm lamp
   // - Any receive condition lights it on the next cycle
   // - Self-clear on: follows the condition
   // - Self-clear off: held until acknowledged
   // - Acknowledge may be a one-cycle pulse
   // - New condition beats a same-cycle acknowledge
   // - Held lamp does not hold the carrier out of service
   //
   // Far-end signalling
   // - Yellow sent while the raw condition stands
   // - Never driven from the held lamp
   // - Stops the cycle after the condition ends
   //
   // Other lamps
   // - Far-end lamp mirrors the received yellow, one cycle late
   // - Missing yellow from the far end simply leaves it dark
   // - Test activity lamp lit for running tests
   // - Test activity lamp lit for disabled alarms
   // - Dark once neither setting remains
   //
   // Timing
   // - All inputs except rst_n taken as synchronous levels
   // - Every lamp is a flop, no glitches at the pins
   // - Phase timer restarts on each state change
   // - Phase timer saturates instead of wrapping
   // - Flash half period is a parameter
   // - Default half period a quarter second, clearly visible
   //
   // Limitations
   // - No filtering of short receive conditions
   // - No lamp test mode
   // - A stuck test source leaves the lamp lit forever
   ////////////////////////////////////////////////////////////////////////

   ////////////////////////////////////////////////////////////////////////
   // Helper functions

   // True on the last cycle of a phase of the given length
   function automatic logic phase_done
   (
      input logic [31:0] elapsed,
      input int unsigned length
   );
      phase_done = (elapsed >= 32'(length - 1));
   endfunction

   // Card-state lamp level for a sequencer state
   function automatic logic card_lamp_for
   (
      input card_state_t state
   );
      card_lamp_for = (state != ST_FLASH_OFF) && (state != ST_ACTIVE);
   endfunction

   // Near-end lamp level from raw condition and held alarm
   function automatic logic near_lamp_for
   (
      input logic alarm,
      input logic held,
      input logic clear
   );
      near_lamp_for = alarm | (held & ~clear);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Reset release synchroniser
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Card-state sequencer
   assign any_slot = slot_a_enabled | slot_b_enabled;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_TESTING:
         begin
            // Hold lit at least the minimum self-test time
            if (selftest_done && phase_done(timer_reg, SELFTEST_MIN))
               state_next = selftest_pass ? ST_FLASH_OFF : ST_FAILED;
         end
         ST_FLASH_OFF:
         begin
            // Dark half of one flash
            if (phase_done(timer_reg, FLASH_HALF))
               state_next = ST_FLASH_ON;
         end
         ST_FLASH_ON:
         begin
            // Lit half of one flash, last one ends the sequence
            if (phase_done(timer_reg, FLASH_HALF))
               state_next = (flashes_reg == 2'(FLASH_COUNT - 1)) ? ST_PASSED : ST_FLASH_OFF;
         end
         ST_PASSED:
         begin
            if (any_slot)
               state_next = ST_ACTIVE;
         end
         ST_ACTIVE:
         begin
            if (!any_slot)
               state_next = ST_PASSED;
         end
         ST_FAILED:
            state_next = ST_FAILED;
         default:
            state_next = ST_TESTING;
      endcase
   end

   // State register
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         state_reg <= ST_TESTING;
      else
         state_reg <= state_next;
   end

   // Phase timer, restarts on every state change
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         timer_reg <= 32'h0000_0000;
      else if (state_next != state_reg)
         timer_reg <= 32'h0000_0000;
      else if (timer_reg != 32'hffff_ffff)
         timer_reg <= timer_reg + 32'h0000_0001;
   end

   // Flash counter
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         flashes_reg <= 2'h0;
      else if (state_reg == ST_TESTING)
         flashes_reg <= 2'h0;
      else if (state_reg == ST_FLASH_ON && state_next == ST_FLASH_OFF)
         flashes_reg <= flashes_reg + 2'h1;
   end

   // Card-state lamp: lit except in flash gaps and the active state
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         card_state_lamp <= 1'b1;
      else
         card_state_lamp <= card_lamp_for(state_next);
   end

   ////////////////////////////////////////////////////////////////////////
   // Near-end alarm detection and latch
   assign near_alarm = rx_alarm.loss_of_signal | rx_alarm.bit_error_over
                     | rx_alarm.slip_over;

   // Self-clear or acknowledge releases the held alarm
   assign alarm_clear = operator_terminal_menu.auto_release | operator_terminal_menu.alarm_ack;

   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         latch_reg <= 1'b0;
      else if (near_alarm)
         latch_reg <= 1'b1;   // Set wins over acknowledge
      else if (alarm_clear)
         latch_reg <= 1'b0;
   end

   // Near-end lamp, clears in the same cycle as the release
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         near_end_alarm_lamp <= 1'b0;
      else
         near_end_alarm_lamp <= near_lamp_for(near_alarm, latch_reg, alarm_clear);
   end

   // Yellow toward the far end from the raw condition
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         yellow_tx <= 1'b0;
      else
         yellow_tx <= near_alarm;
   end

   // Far-end lamp follows the received yellow
   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         far_end_alarm_lamp <= 1'b0;
      else
         far_end_alarm_lamp <= yellow_rx;
   end

   ////////////////////////////////////////////////////////////////////////
   // Test activity lamp
   assign test_activity_lamp_request = operator_terminal_menu.tests_running
                        | operator_terminal_menu.alarms_disabled;

   always_ff @(posedge ref_clk or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
         test_activity_lamp <= 1'b0;
      else
         test_activity_lamp <= test_activity_lamp_request;
   end

endmodule
`default_nettype wire

// ==== dv/lamp_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
module lamp_checker
   import lamp_pkg::*;
(
   input wire logic           ref_clk,
   input wire logic           rst_n,
   input wire logic           slot_a_enabled,
   input wire logic           slot_b_enabled,
   input wire rx_alarm_t      rx_alarm,
   input wire logic           yellow_rx,
   input wire operator_menu_t operator_terminal_menu,
   input wire logic           card_state_lamp,
   input wire logic           near_end_alarm_lamp,
   input wire logic           far_end_alarm_lamp,
   input wire logic           test_activity_lamp,
   input wire logic           yellow_tx
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // Any near-end condition
   wire logic al = |rx_alarm;
   wire logic ar = operator_terminal_menu.auto_release;
   wire logic ack = operator_terminal_menu.alarm_ack;
   ////////////////////////////////////////////////////////////////////////////
   property p_red; al |=> near_end_alarm_lamp; endproperty
   a_red: assert property (p_red) else $error("near lamp not lit");
   property p_ytx; 1 |=> yellow_tx == $past(al); endproperty
   a_ytx: assert property (p_ytx) else $error("yellow send wrong");
   property p_auto; !al && ar |=> !near_end_alarm_lamp; endproperty
   a_auto: assert property (p_auto) else $error("no self clear");
   property p_hold; near_end_alarm_lamp && !ar && !ack |=> near_end_alarm_lamp; endproperty
   a_hold: assert property (p_hold) else $error("latch lost");
   property p_ack; !al && ack |=> !near_end_alarm_lamp; endproperty
   a_ack: assert property (p_ack) else $error("ack ignored");
   property p_far; 1 |=> far_end_alarm_lamp == $past(yellow_rx); endproperty
   a_far: assert property (p_far) else $error("far lamp wrong");
   property p_tst; 1 |=> test_activity_lamp == $past(operator_terminal_menu.tests_running ||
      operator_terminal_menu.alarms_disabled); endproperty
   a_tst: assert property (p_tst) else $error("test lamp wrong");
   property p_slot; !card_state_lamp && (slot_a_enabled || slot_b_enabled) |=> !card_state_lamp;
   endproperty
   a_slot: assert property (p_slot) else $error("lamp relit early");
endmodule
bind t1_card_alarm_led_control lamp_checker u_chk (.*);
`default_nettype wire

// ==== dv/far_end_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module far_end_model #(parameter bit HAS_YELLOW = 1'b1)
(
   input  wire logic ref_clk,
   input  wire logic own_red,
   output logic      yellow_rx
);
   // Returns yellow while its own receive side is in red alarm
   always_ff @(posedge ref_clk) yellow_rx <= own_red & HAS_YELLOW;
endmodule
`default_nettype wire

// ==== dv/t1_card_alarm_led_control_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module t1_card_alarm_led_control_test;
   import lamp_pkg::*;
   logic ref_clk = 0, rst_n = 0, done = 0, pass = 0, sa = 0, sb = 0, red = 0;
   rx_alarm_t rx = '0;
   operator_menu_t menu = '0;
   logic card, near, far, tst, ytx, yrx, en, yq, mq;
   int err_total = 0, num_checks = 0, cyc = 0, seed = 32'he1ff2b46, i;
   t1_card_alarm_led_control #(.SELFTEST_MIN(10), .FLASH_HALF(4)) u_dut (.ref_clk, .rst_n,
      .selftest_done(done), .selftest_pass(pass), .slot_a_enabled(sa), .slot_b_enabled(sb),
      .rx_alarm(rx), .yellow_rx(yrx), .operator_terminal_menu(menu), .card_state_lamp(card),
      .near_end_alarm_lamp(near), .far_end_alarm_lamp(far), .test_activity_lamp(tst),
      .yellow_tx(ytx));
   far_end_model u_far (.ref_clk, .own_red(red), .yellow_rx(yrx));
   initial forever #50 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t %h %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (err_total == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick(input int n); repeat (n) @(negedge ref_clk); endtask
   // Expected near-end lamp: set by alarm, cleared by self clear or ack
   function automatic logic near_next(logic cur, rx_alarm_t a, operator_menu_t m);
      return (|a) | (cur & ~m.auto_release & ~m.alarm_ack);
   endfunction
   // Cycle ceiling
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_total++;
         report_and_stop;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(8);
      rst_n = 1;
      done = 1;
      pass = 1;
      for (i = 0; i < 10; i++) begin tick(1); chk(card, 1'b1); end
      for (i = 0; i < 30 && card !== 1'b0; i++) tick(1);
      for (i = 0; i < 28; i++) begin chk(card, i >= 24 || (i / 4) % 2); tick(1); end
      for (i = 0; i < 4; i++) begin {sa, sb} = 2'(8'hb4 >> (6 - 2 * i)); tick(1); chk(card, i == 3); end
      en = 0;
      for (i = 0; i < 400; i++)
      begin
         yq = yrx;
         rx = ($random(seed) % 3 == 0) ? rx_alarm_t'(3'($random(seed))) : '0;
         menu = operator_menu_t'(4'($random(seed)));
         red = 1'($random(seed));
         mq = menu.tests_running | menu.alarms_disabled;
         en = near_next(en, rx, menu);
         tick(1);
         chk(near, en);
         chk(ytx, |rx);
         chk(far, yq);
         chk(tst, mq);
      end
      {done, pass, rx, menu, red} = '0;
      rst_n = 0;
      tick(8);
      rst_n = 1;
      done = 1;
      sa = 1;
      tick(40);
      chk(card, 1'b1);
      report_and_stop;
   end
endmodule
`default_nettype wire
